// >>> hw/hwmon_regs.svh
`ifndef HWMON_REGS_SVH
`define HWMON_REGS_SVH
// ==========================================
// Register offsets
`define ADDR_RUN_CONTROL 8'h40
`define ADDR_IRQ_STATUS_ONE 8'h41
`define ADDR_IRQ_STATUS_TWO 8'h42
`define ADDR_SPECIAL_FUNCTION 8'h7c
`define ADDR_IRQ_ENABLE_VOLTAGE 8'h7e
`define ADDR_DEVICE_CONFIG 8'h7f
`define ADDR_IRQ_ENABLE_FAN 8'h80
`define ADDR_IRQ_ENABLE_TEMP 8'h82
`define ADDR_ENABLE_ONE 8'h83
`define ADDR_ENABLE_TWO 8'h84
// ==========================================
// Field positions
`define BIT_START 0
`define BIT_CYCLE_MODE 1
`define BIT_GLOBAL_EN 2
`define BIT_SOFT_RESET 7
`define BIT_ROUTE_TACH_PIN3 0
`define BIT_ROUTE_DRIVE2 1
`define BIT_GROUP_EN 0
// ==========================================
// Reset values
`define RST_STATUS 8'h00
`define RST_SPECIAL_FUNCTION 8'h40
`define RST_ENABLE 8'hff
`define RST_CONFIG 8'h00
// ==========================================
// Readings and timing
`define READ_FAULT 8'h80
`define READ_DISABLED 8'h00
`define TEMP_CONV_CLOCKS 96
`define VOLT_CONV_CLOCKS 68
`define CONV_CLOCK_HZ 45000
`define IDLE_TIME_MS 1000
`define IDLE_CONV_CLOCKS ((`IDLE_TIME_MS * `CONV_CLOCK_HZ) / 1000)
`define NUM_STEPS 8
`endif

// >>> hw/hwmon_pkg.sv
package hwmon_pkg;
  typedef enum logic [2:0] {
    STEP_REMOTE1 = 3'h0,
    STEP_AMBIENT = 3'h1,
    STEP_VCC = 3'h2,
    STEP_V12 = 3'h3,
    STEP_V5 = 3'h4,
    STEP_V25 = 3'h5,
    STEP_VCORE = 3'h6,
    STEP_REMOTE2 = 3'h7
  } step_type;

  typedef enum logic [1:0] {
    SEQ_STOPPED = 2'h0,
    SEQ_CONVERT = 2'h1,
    SEQ_IDLE = 2'h2
  } seq_state_type;

  typedef struct packed {
    logic open_pair;
    logic pos_short;
    logic neg_to_vcc;
    logic neg_to_gnd;
  } diode_fault_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;
endpackage

// >>> hw/hwmon_seq.sv
// Operation
// R1: Writing one to start bit starts sequencing from remote diode 1.
// R2: Fixed order: remote1, ambient, VCC, 12V, 5V, 2.5V, core, remote2.
// R3: Continuous mode restarts the eight steps immediately after the last.
// R4: Cycle mode converts each input once, then idles about one second.
// R5: Special function bit 1 selects continuous or cycle mode.
// R6: Temperature takes 96 conversion clocks, voltage 68, times averaging count.
// R7: Result at or beyond a limit sets the matching status bit.
// R8: Readings always readable; in cycle mode change once per cycle.
// R9: Status bits stay set until read; read clears only if cause gone.
// R10: Status registers ignore writes; reset and soft reset give 0x00.
// R11: Cleared individual enable stops its event setting the status bit.
// R12: Open pair or terminal short to supply or ground sets diode fault.
// R13: Diode fault loads 80h except negative terminal grounded; sets limit error.
// R14: Diode fault bits never drive the interrupt output directly.
// R15: Remote reading of 80h forces that zone's fan drives to full.
// R16: Disabled diode: no fault bit, loads 00h on fault, else normal reading.
// R17: Config bit 1 routes interrupt to drive pin 2, bit 0 to tach 3.
// R18: Special function bit 2 is the global interrupt enable.
// R19: Bit 0 of three enable registers gates temp, voltage, fan groups.
// R20: Interrupt low while any fully enabled status bit is set.
// R21: Host clears global enable before status reads, then sets it again.
// R22: Host may release the interrupt with an alert response read.
// R23: After answering the alert response, global enable is cleared.
// R24: Interrupt asserts only while monitoring runs.
// R25: Clearing start stops new conversions and holds readings.
`include "hwmon_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module hwmon_seq #(
  parameter int unsigned IDLE_CLOCKS = `IDLE_CONV_CLOCKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Conversion clock from oscillator pin
  input wire logic conv_clk,
  // Register port
  input wire hwmon_pkg::reg_req_type req,
  output logic [7:0] rdata,
  // Alert response acknowledged by serial engine
  input wire logic ara_ack,
  // Analog front end
  input wire logic [7:0] adc_value,
  input wire hwmon_pkg::diode_fault_type fault1,
  input wire hwmon_pkg::diode_fault_type fault2,
  input wire logic [15:0] lim_low_flat,
  input wire logic [15:0] lim_high_flat,
  input wire logic [5:0] fan_error,
  output logic [2:0] conv_select,
  // Readings and pins
  output logic [63:0] readings,
  output logic [1:0] zone_full_on,
  output logic irq_n,
  output logic drive2_irq_oe_n,
  output logic tach_pin3_irq_oe_n,
  output logic irq_busy
);
  // ==========================================
  // Limit lookup and averaging
  function automatic logic [7:0] byte_of(input logic [63:0] v, input logic [2:0] i);
    byte_of = v[{i, 3'h0} +: 8];
  endfunction

  function automatic logic is_temp(input logic [2:0] s);
    is_temp = (s == 3'h0) || (s == 3'h1) || (s == 3'h7);
  endfunction

  // Priority encoded averaging count
  function automatic logic [7:0] avg_count(input logic [2:0] avg, input logic remote, input logic temp);
    if (avg[2]) begin
      avg_count = 8'h20;
    end else if (avg[1]) begin
      avg_count = 8'h10;
    end else if (avg[0]) begin
      avg_count = remote ? 8'h10 : 8'h01;
    end else begin
      avg_count = remote ? 8'h80 : 8'h08;
    end
  endfunction

  // ==========================================
  // Conversion clock synchroniser
  logic cclk_s1_q, cclk_s2_q, cclk_s3_q;
  logic tick;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cclk_s1_q <= 1'b0;
      cclk_s2_q <= 1'b0;
      cclk_s3_q <= 1'b0;
    end else if (ce) begin
      cclk_s1_q <= conv_clk;
      cclk_s2_q <= cclk_s1_q;
      cclk_s3_q <= cclk_s2_q;
    end
  end
  assign tick = cclk_s2_q && !cclk_s3_q;

  // ==========================================
  // Registers
  logic [7:0] run_q, sfr_q, en_volt_q, en_fan_q, en_temp_q, cfg_q, en1_q, en2_q;
  logic [7:0] st1_q, st2_q;
  logic soft_rst;
  logic wr_run, wr_sfr;
  assign soft_rst = req.wr && (req.addr == `ADDR_DEVICE_CONFIG) && req.wdata[`BIT_SOFT_RESET];
  assign wr_run = req.wr && (req.addr == `ADDR_RUN_CONTROL);
  assign wr_sfr = req.wr && (req.addr == `ADDR_SPECIAL_FUNCTION);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 8'h00;
      sfr_q <= `RST_SPECIAL_FUNCTION;
      en_volt_q <= `RST_ENABLE;
      en_fan_q <= `RST_ENABLE;
      en_temp_q <= `RST_ENABLE;
      cfg_q <= `RST_CONFIG;
      en1_q <= `RST_ENABLE;
      en2_q <= `RST_ENABLE;
    end else if (ce) begin
      if (soft_rst) begin
        run_q <= 8'h00;
        sfr_q <= `RST_SPECIAL_FUNCTION;
        en_volt_q <= `RST_ENABLE;
        en_fan_q <= `RST_ENABLE;
        en_temp_q <= `RST_ENABLE;
        cfg_q <= `RST_CONFIG;
        en1_q <= `RST_ENABLE;
        en2_q <= `RST_ENABLE;
      end else begin
        if (wr_run) begin
          run_q <= req.wdata;
        end
        if (wr_sfr) begin
          sfr_q <= req.wdata;
        end else if (ara_ack) begin
          sfr_q[`BIT_GLOBAL_EN] <= 1'b0; // see R22 see R23
        end
        if (req.wr && req.addr == `ADDR_IRQ_ENABLE_VOLTAGE) begin
          en_volt_q <= req.wdata;
        end
        if (req.wr && req.addr == `ADDR_IRQ_ENABLE_FAN) begin
          en_fan_q <= req.wdata;
        end
        if (req.wr && req.addr == `ADDR_IRQ_ENABLE_TEMP) begin
          en_temp_q <= req.wdata;
        end
        if (req.wr && req.addr == `ADDR_DEVICE_CONFIG) begin
          cfg_q <= {1'b0, req.wdata[6:0]};
        end
        if (req.wr && req.addr == `ADDR_ENABLE_ONE) begin
          en1_q <= req.wdata;
        end
        if (req.wr && req.addr == `ADDR_ENABLE_TWO) begin
          en2_q <= req.wdata;
        end
      end
    end
  end

  // ==========================================
  // Sequencer
  hwmon_pkg::seq_state_type state_q;
  logic [2:0] step_q;
  logic [7:0] clk_cnt_q;
  logic [7:0] avg_cnt_q;
  logic [31:0] idle_cnt_q;
  logic running, conv_end, step_done, cycle_mode;
  assign running = run_q[`BIT_START];
  assign cycle_mode = sfr_q[`BIT_CYCLE_MODE]; // see R5
  assign conv_end = tick && (clk_cnt_q == (is_temp(step_q) ? 8'(`TEMP_CONV_CLOCKS - 1)
                                                           : 8'(`VOLT_CONV_CLOCKS - 1))); // see R6
  assign step_done = conv_end && (avg_cnt_q == 8'(avg_count(sfr_q[7:5],
    (step_q == 3'h0) || (step_q == 3'h7), is_temp(step_q)) - 8'h01));
  assign conv_select = step_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= hwmon_pkg::SEQ_STOPPED;
      step_q <= 3'h0;
      clk_cnt_q <= 8'h00;
      avg_cnt_q <= 8'h00;
      idle_cnt_q <= 32'h0;
    end else if (ce) begin
      if (!running || soft_rst) begin
        state_q <= hwmon_pkg::SEQ_STOPPED; // see R25
      end else begin
        unique case (state_q)
          hwmon_pkg::SEQ_STOPPED: begin
            state_q <= hwmon_pkg::SEQ_CONVERT; // see R1
            step_q <= 3'h0;
            clk_cnt_q <= 8'h00;
            avg_cnt_q <= 8'h00;
          end
          hwmon_pkg::SEQ_CONVERT: begin
            if (conv_end) begin
              clk_cnt_q <= 8'h00;
              avg_cnt_q <= step_done ? 8'h00 : avg_cnt_q + 8'h01;
            end else if (tick) begin
              clk_cnt_q <= clk_cnt_q + 8'h01;
            end
            if (step_done) begin
              step_q <= step_q + 3'h1; // see R2 see R3
              if (step_q == 3'h7 && cycle_mode) begin
                state_q <= hwmon_pkg::SEQ_IDLE; // see R4
                idle_cnt_q <= 32'h0;
              end
            end
          end
          hwmon_pkg::SEQ_IDLE: begin
            if (tick) begin
              if (idle_cnt_q == IDLE_CLOCKS - 1) begin
                state_q <= hwmon_pkg::SEQ_CONVERT;
              end else begin
                idle_cnt_q <= idle_cnt_q + 32'h1;
              end
            end
          end
          default: state_q <= hwmon_pkg::SEQ_STOPPED;
        endcase
      end
    end
  end

  // ==========================================
  // Result and comparison
  logic [7:0] result, low, high;
  logic chan_enabled, has_fault, violate;
  hwmon_pkg::diode_fault_type fault;
  always_comb begin
    fault = (step_q == 3'h7) ? fault2 : fault1;
    chan_enabled = (step_q == 3'h7) ? en_temp_q[2] : en_temp_q[1];
    has_fault = |fault; // see R12
    result = adc_value;
    if ((step_q == 3'h0 || step_q == 3'h7) && has_fault && !fault.neg_to_gnd) begin
      result = chan_enabled ? `READ_FAULT : `READ_DISABLED; // see R13 see R16
    end
    low = byte_of({lim_low_flat, lim_low_flat, lim_low_flat, lim_low_flat}, step_q);
    high = byte_of({lim_high_flat, lim_high_flat, lim_high_flat, lim_high_flat}, step_q);
    if (is_temp(step_q)) begin
      violate = ($signed(result) <= $signed(low)) || ($signed(result) >= $signed(high)); // see R7
    end else begin
      violate = (result <= low) || (result >= high); // see R7
    end
  end

  // Readings update once per step, so once per cycle in cycle mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readings <= 64'h0;
    end else if (ce && state_q == hwmon_pkg::SEQ_CONVERT && step_done && running) begin
      readings[{step_q, 3'h0} +: 8] <= result; // see R8
    end
  end

  // Zone full-on for diode error reading
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      zone_full_on <= 2'b00;
    end else if (ce) begin
      zone_full_on <= {readings[63:56] == `READ_FAULT, readings[7:0] == `READ_FAULT}; // see R15
    end
  end

  // ==========================================
  // Status: bit i of one = step i error; two = diode faults and fans
  logic [7:0] cond1_q, cond2_q;
  logic [7:0] set1, set2, en_ind1, en_ind2;
  logic rd1, rd2, capture;
  assign capture = ce && state_q == hwmon_pkg::SEQ_CONVERT && step_done && running;
  assign rd1 = req.rd && (req.addr == `ADDR_IRQ_STATUS_ONE);
  assign rd2 = req.rd && (req.addr == `ADDR_IRQ_STATUS_TWO);
  assign en_ind1 = en1_q;
  assign en_ind2 = en2_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cond1_q <= 8'h00;
      cond2_q <= 8'h00;
    end else if (ce) begin
      if (capture) begin
        cond1_q[step_q] <= violate;
        if (step_q == 3'h0) begin
          cond2_q[0] <= has_fault && en_temp_q[1];
        end
        if (step_q == 3'h7) begin
          cond2_q[1] <= has_fault && en_temp_q[2];
        end
      end
      cond2_q[7:2] <= fan_error;
    end
  end

  always_comb begin
    set1 = 8'h00;
    set2 = {cond2_q[7:2], 2'b00};
    if (capture) begin
      set1[step_q] = violate;
      set2[0] = (step_q == 3'h0) && has_fault && en_temp_q[1]; // see R16
      set2[1] = (step_q == 3'h7) && has_fault && en_temp_q[2];
    end
    set1 = set1 & en_ind1; // see R11
    set2 = set2 & en_ind2;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st1_q <= `RST_STATUS;
      st2_q <= `RST_STATUS;
    end else if (ce) begin
      if (soft_rst) begin
        st1_q <= `RST_STATUS; // see R10
        st2_q <= `RST_STATUS;
      end else begin
        st1_q <= (rd1 ? (st1_q & cond1_q) : st1_q) | set1; // see R9
        st2_q <= (rd2 ? (st2_q & cond2_q) : st2_q) | set2; // see R9
      end
    end
  end

  // ==========================================
  // Interrupt
  logic temp_pend, volt_pend, fan_pend, irq_active;
  assign temp_pend = |({st1_q[7], st1_q[1:0]} & {en1_q[7], en1_q[1:0]}) && en_temp_q[`BIT_GROUP_EN]; // see R14
  assign volt_pend = |(st1_q[6:2] & en1_q[6:2]) && en_volt_q[`BIT_GROUP_EN]; // see R19
  assign fan_pend = |(st2_q[7:2] & en2_q[7:2]) && en_fan_q[`BIT_GROUP_EN]; // see R19
  assign irq_busy = temp_pend || volt_pend || fan_pend;
  assign irq_active = irq_busy && sfr_q[`BIT_GLOBAL_EN] && running; // see R18 see R20 see R24

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_n <= 1'b1;
      drive2_irq_oe_n <= 1'b1;
      tach_pin3_irq_oe_n <= 1'b1;
    end else if (ce) begin
      irq_n <= !irq_active;
      drive2_irq_oe_n <= !(irq_active && cfg_q[`BIT_ROUTE_DRIVE2]); // see R17
      tach_pin3_irq_oe_n <= !(irq_active && cfg_q[`BIT_ROUTE_TACH_PIN3]); // see R17
    end
  end

  // ==========================================
  // Read data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (ce && req.rd) begin
      case (req.addr)
        `ADDR_RUN_CONTROL: rdata <= run_q;
        `ADDR_IRQ_STATUS_ONE: rdata <= st1_q;
        `ADDR_IRQ_STATUS_TWO: rdata <= st2_q;
        `ADDR_SPECIAL_FUNCTION: rdata <= sfr_q;
        `ADDR_IRQ_ENABLE_VOLTAGE: rdata <= en_volt_q;
        `ADDR_DEVICE_CONFIG: rdata <= cfg_q;
        `ADDR_IRQ_ENABLE_FAN: rdata <= en_fan_q;
        `ADDR_IRQ_ENABLE_TEMP: rdata <= en_temp_q;
        `ADDR_ENABLE_ONE: rdata <= en1_q;
        `ADDR_ENABLE_TWO: rdata <= en2_q;
        default: rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================
  // Checks
  property p_irq_needs_run;
    @(posedge clk) disable iff (!nrst) (ce && !running) |=> irq_n;
  endproperty
  a_irq_needs_run: assert property (p_irq_needs_run) else $error("irq while stopped"); // see R24

  property p_ara_clears_en;
    @(posedge clk) disable iff (!nrst) (ce && ara_ack && !wr_sfr && !soft_rst) |=> !sfr_q[`BIT_GLOBAL_EN];
  endproperty
  a_ara_clears_en: assert property (p_ara_clears_en) else $error("global enable kept after alert"); // see R23

  property p_status_sticky;
    @(posedge clk) disable iff (!nrst) (ce && !rd1 && !soft_rst && st1_q[0]) |=> st1_q[0];
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status lost without read"); // see R9

  property p_read_keeps_active;
    @(posedge clk) disable iff (!nrst) (ce && rd1 && !soft_rst && st1_q[1] && cond1_q[1]) |=> st1_q[1];
  endproperty
  a_read_keeps_active: assert property (p_read_keeps_active) else $error("active status cleared"); // see R9

  property p_soft_reset;
    @(posedge clk) disable iff (!nrst) (ce && soft_rst) |=> (st1_q == 8'h00 && st2_q == 8'h00);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("status kept over soft reset"); // see R10

  property p_global_gate;
    @(posedge clk) disable iff (!nrst) (ce && !sfr_q[`BIT_GLOBAL_EN]) |=> irq_n;
  endproperty
  a_global_gate: assert property (p_global_gate) else $error("irq without global enable"); // see R18

  property p_irq_follows;
    @(posedge clk) disable iff (!nrst) (ce && irq_busy && sfr_q[`BIT_GLOBAL_EN] && running) |=> !irq_n;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq missing"); // see R20

  property p_route_tach_pin3;
    @(posedge clk) disable iff (!nrst) (ce && !cfg_q[`BIT_ROUTE_TACH_PIN3]) |=> tach_pin3_irq_oe_n;
  endproperty
  a_route_tach_pin3: assert property (p_route_tach_pin3) else $error("tach_pin3 driven unrouted"); // see R17

  sequence s_step_end;
    capture ##1 1'b1;
  endsequence
  property p_step_advance;
    @(posedge clk) disable iff (!nrst) (capture && step_q != 3'h7) |=> (step_q == $past(step_q) + 3'h1);
  endproperty
  a_step_advance: assert property (p_step_advance) else $error("step order broken"); // see R2

  property p_cycle_idle;
    @(posedge clk) disable iff (!nrst) (capture && step_q == 3'h7 && cycle_mode && !soft_rst)
      |=> (state_q == hwmon_pkg::SEQ_IDLE);
  endproperty
  a_cycle_idle: assert property (p_cycle_idle) else $error("cycle mode did not idle"); // see R4

  property p_cont_restart;
    @(posedge clk) disable iff (!nrst) (capture && step_q == 3'h7 && !cycle_mode && !soft_rst)
      |=> (state_q == hwmon_pkg::SEQ_CONVERT && step_q == 3'h0);
  endproperty
  a_cont_restart: assert property (p_cont_restart) else $error("continuous mode did not restart"); // see R3
endmodule // hwmon_seq
`default_nettype wire

// >>> tb/hwmon_front_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Analog front end and oscillator stand-in
module hwmon_front_model (
  // Step selection from the sequencer, reading table from the test
  input wire logic [2:0] conv_select,
  input wire logic [63:0] table_vals,
  // Toward the sequencer
  output logic conv_clk,
  output wire logic [7:0] adc_value
);
  // Oscillator runs free, 64 ns period
  initial begin
    conv_clk = 1'b0;
    forever #32 conv_clk = ~conv_clk;
  end
  assign adc_value = table_vals[conv_select * 8 +: 8];
endmodule // hwmon_front_model
`default_nettype wire

// >>> tb/monitor_sequencer_and_alert_test.sv
`timescale 1ns/1ns
`default_nettype none
module monitor_sequencer_and_alert_test;
  logic clk, nrst, ce, ara_ack, conv_clk;
  hwmon_pkg::reg_req_type req;
  hwmon_pkg::diode_fault_type fault1, fault2;
  logic [7:0] rdata, adc_value, rd_val;
  logic [15:0] lim_low_flat, lim_high_flat;
  logic [5:0] fan_error;
  logic [2:0] conv_select;
  logic [63:0] readings, tbl, held;
  logic [1:0] zone_full_on;
  logic irq_n, drive2_irq_oe_n, tach_pin3_irq_oe_n, irq_busy;
  int num_errors, n_tests;

  // ==========================================
  // Instances
  hwmon_seq #(.IDLE_CLOCKS(4)) i_dut (
    .clk(clk), .nrst(nrst), .ce(ce), .conv_clk(conv_clk), .req(req), .rdata(rdata),
    .ara_ack(ara_ack), .adc_value(adc_value), .fault1(fault1), .fault2(fault2),
    .lim_low_flat(lim_low_flat), .lim_high_flat(lim_high_flat), .fan_error(fan_error),
    .conv_select(conv_select), .readings(readings), .zone_full_on(zone_full_on), .irq_n(irq_n),
    .drive2_irq_oe_n(drive2_irq_oe_n), .tach_pin3_irq_oe_n(tach_pin3_irq_oe_n), .irq_busy(irq_busy)
  );
  hwmon_front_model i_front (
    .conv_select(conv_select), .table_vals(tbl), .conv_clk(conv_clk), .adc_value(adc_value)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================
  // Shared tasks
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk);
    req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    rd_val = rdata;
    check($sformatf("register %h", addr), 64'(exp), 64'(rd_val));
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Waits for the sequencer to leave its step, then checks the new one
  task automatic next_step(input logic [2:0] exp);
    logic [2:0] cur;
    int n;
    cur = conv_select;
    n = 0;
    while (conv_select === cur && n < 40000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40000) begin
      num_errors++;
      $display("ERROR step wait expected %h seen %h", exp, conv_select);
      end_of_test();
    end
    #1;
    check("conv_select", 64'(exp), 64'(conv_select));
  endtask

  // ==========================================
  // Scenarios
  task automatic test_reset_values();
    check("irq_n", 64'h1, 64'(irq_n));
    check("readings", 64'h0, readings);
    check_reg(8'h41, 8'h00);
    check_reg(8'h42, 8'h00);
    check_reg(8'h7c, 8'h40);
    check_reg(8'h10, 8'h00);
    wr_reg(8'h41, 8'hff);
    wr_reg(8'h42, 8'hff);
    check_reg(8'h41, 8'h00);
    check_reg(8'h42, 8'h00);
  endtask

  task automatic test_first_pass();
    wr_reg(8'h7e, 8'h01);
    wr_reg(8'h80, 8'h00);
    wr_reg(8'h82, 8'h07);
    wr_reg(8'h83, 8'hff);
    wr_reg(8'h84, 8'hff);
    wr_reg(8'h7f, 8'h03);
    wr_reg(8'h7c, 8'h20);
    wr_reg(8'h40, 8'h01);
    next_step(3'h1);
    next_step(3'h2);
    next_step(3'h3);
  endtask

  task automatic test_alert();
    check_reg(8'h41, 8'h04);
    check_reg(8'h41, 8'h04);
    check("irq_n", 64'h1, 64'(irq_n));
    check("irq_busy", 64'h1, 64'(irq_busy));
    wr_reg(8'h7c, 8'h24);
    settle();
    check("irq_n", 64'h0, 64'(irq_n));
    check("drive2_oe_n", 64'h0, 64'(drive2_irq_oe_n));
    check("tach_pin3_oe_n", 64'h0, 64'(tach_pin3_irq_oe_n));
    wr_reg(8'h7f, 8'h01);
    settle();
    check("drive2_oe_n", 64'h1, 64'(drive2_irq_oe_n));
    check("tach_pin3_oe_n", 64'h0, 64'(tach_pin3_irq_oe_n));
    wr_reg(8'h7e, 8'h00);
    settle();
    check("irq_n", 64'h1, 64'(irq_n));
    wr_reg(8'h7e, 8'h01);
    settle();
    check("irq_n", 64'h0, 64'(irq_n));
    @(posedge clk);
    ara_ack <= 1'b1;
    @(posedge clk);
    ara_ack <= 1'b0;
    settle();
    check("irq_n", 64'h1, 64'(irq_n));
    check_reg(8'h7c, 8'h20);
    wr_reg(8'h7c, 8'h24);
  endtask

  task automatic test_pass_end();
    next_step(3'h4);
    next_step(3'h5);
    next_step(3'h6);
    next_step(3'h7);
    next_step(3'h0);
    settle();
    check("readings", tbl, readings);
    check("zone_full_on", 64'h0, 64'(zone_full_on));
    @(posedge clk);
    fault1 <= '{open_pair: 1'b1, pos_short: 1'b0, neg_to_vcc: 1'b0, neg_to_gnd: 1'b0};
    tbl[23:16] <= 8'h20;
    tbl[15:8] <= 8'h7f;
    wr_reg(8'h83, 8'hfd);
  endtask

  task automatic test_diode_fault();
    next_step(3'h1);
    settle();
    check("remote1 reading", 64'h80, 64'(readings[7:0]));
    check("zone_full_on", 64'h1, 64'(zone_full_on));
    next_step(3'h2);
    next_step(3'h3);
    settle();
    check_reg(8'h42, 8'h01);
    check_reg(8'h41, 8'h05);
    check_reg(8'h41, 8'h01);
    check("irq_n", 64'h0, 64'(irq_n));
  endtask

  task automatic test_stop_and_soft_reset();
    wr_reg(8'h40, 8'h00);
    settle();
    held = readings;
    repeat (2000) @(posedge clk);
    #1;
    check("readings", held, readings);
    check("irq_n", 64'h1, 64'(irq_n));
    wr_reg(8'h7f, 8'h80);
    check_reg(8'h41, 8'h00);
    check_reg(8'h42, 8'h00);
    check_reg(8'h7c, 8'h40);
    check_reg(8'h7f, 8'h00);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    ara_ack = 1'b0;
    req = '0;
    fault1 = '0;
    fault2 = '0;
    lim_low_flat = 16'h0101;
    lim_high_flat = 16'h7e7e;
    fan_error = 6'h00;
    num_errors = 0;
    n_tests = 0;
    for (int i = 0; i < 8; i++) begin
      tbl[i * 8 +: 8] = 8'h10 + 8'(i);
    end
    tbl[23:16] = 8'h90;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    test_reset_values();
    test_first_pass();
    test_alert();
    test_pass_end();
    test_diode_fault();
    test_stop_and_soft_reset();
    end_of_test();
  end
endmodule // monitor_sequencer_and_alert_test
`default_nettype wire
